// >>> dv/crystal_model.sv
`timescale 1ns/1ps
// crystal plus amplitude detector: settles a fixed time after the in pin is claimed
module crystal_model
#(
	parameter int SETTLE = 6
)
(
	input  wire logic clock,
	input  wire logic claim,
	input  wire logic enable,
	output logic      amp_detect_stable
);
	int count;

	// no oscillation without the pin claim, so stability drops with it
	always @(posedge clock)
	begin
		if (!claim || !enable)
			count <= 0;
		else if (count < SETTLE)
			count <= count + 1;
	end
	assign amp_detect_stable = (count == SETTLE);
endmodule // crystal_model

// >>> dv/tb_external_oscillator_control.sv
`timescale 1ns/1ps
module tb_external_oscillator_control;
	logic                   clock, resetn, sfr_wr, look, osc_en, sfr_sel, stable;
	logic [7:0]             sfr_addr, sfr_page, sfr_wdata, sfr_rdata, r;
	ext_osc_pkg::osc_ctrl_s osc_ctrl;
	logic [19:0]            notes[$];
	logic [2:0]             mode_m, freq_m;
	int                     errors, check_count, seed, i;
	localparam int          settle_wait = 25000; // 1 ms of 40 ns cycles

	external_oscillator_control dut_u (.clock(clock), .resetn(resetn), .sfr_addr(sfr_addr),
		.sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.sfr_sel(sfr_sel), .amp_detect_stable(stable), .osc_ctrl(osc_ctrl));
	crystal_model xtal_u (.clock(clock), .claim(osc_ctrl.crystal_in_pin_claim),
		.enable(osc_en), .amp_detect_stable(stable));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// expected {sel, read data, controls} from the shadow of the register
	function logic [19:0] expect_of(input logic hit, input logic flag);
		ext_osc_pkg::osc_ctrl_s c;
		case (mode_m)
			3'h0, 3'h1: c.kind = ext_osc_pkg::OSC_OFF;
			3'h2, 3'h3: c.kind = ext_osc_pkg::OSC_LOGIC;
			3'h4: c.kind = ext_osc_pkg::OSC_RC;
			3'h5: c.kind = ext_osc_pkg::OSC_CAP;
			default: c.kind = ext_osc_pkg::OSC_XTAL;
		endcase
		c.div_by_two = (mode_m == 3'h3) || (mode_m == 3'h7);
		c.freq_control = freq_m;
		c.crystal_in_pin_claim = (mode_m[2:1] == 2'h3);
		c.crystal_out_pin_claim = (mode_m[2:1] != 2'h0);
		return {hit, hit ? {flag, mode_m, 1'b0, freq_m} : 8'h00, c};
	endfunction

	// strobe stays up so back-to-back writes never assign it twice in one step
	task write_reg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		sfr_addr = a;
		sfr_page = p;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clock);
		if (a == 8'h9f && p == 8'h0f)
		begin
			mode_m = d[6:4];
			freq_m = d[2:0];
		end
	endtask

	task read_reg(input logic [7:0] a, input logic [7:0] p, input logic flag);
		sfr_wr = 1'b0;
		sfr_addr = a;
		sfr_page = p;
		look = 1'b1;
		notes.push_back(expect_of(a == 8'h9f && p == 8'h0f, flag));
		@(negedge clock);
		look = 1'b0;
	endtask

	task compare(input logic [19:0] got, input logic [19:0] want);
		check_count++;
		if (got !== want)
		begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask

	task final_report;
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// monitor: takes the oldest note whenever a read is presented
	always @(posedge clock)
		if (look === 1'b1)
			compare({sfr_sel, sfr_rdata, osc_ctrl}, notes.pop_front());

	initial
	begin
		seed = 19341;
		{resetn, sfr_wr, look, osc_en, mode_m, freq_m} = '0;
		{sfr_addr, sfr_page, sfr_wdata} = '0;
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		read_reg(8'h9f, 8'h0f, 1'b0);
		for (i = 0; i < 8; i++)
		begin
			r = $random(seed);
			write_reg(8'h9f, 8'h0f, {r[7], i[2:0], 1'b0, r[2:0]});
			read_reg(8'h9f, 8'h0f, 1'b0);
		end
		r = $random(seed);
		write_reg(8'h9f, 8'h0e, r);
		write_reg(8'h9e, 8'h0f, ~r);
		read_reg(8'h9e, 8'h0f, 1'b0);
		read_reg(8'h9f, 8'h0f, 1'b0);
		// oscillator off (mode 000) first; the bench has no pins to drive high or make analog
		write_reg(8'h9f, 8'h0f, 8'h00);
		read_reg(8'h9f, 8'h0f, 1'b0);
		osc_en = 1'b1;
		write_reg(8'h9f, 8'h0f, 8'h67);
		read_reg(8'h9f, 8'h0f, 1'b0);
		// a full millisecond before the first look at the flag, then a bounded poll
		repeat (settle_wait) @(negedge clock);
		for (i = 0; i < 50 && sfr_rdata[7] !== 1'b1; i++)
			@(negedge clock);
		if (i == 50)
			errors++;
		else
		begin
			read_reg(8'h9f, 8'h0f, 1'b1);
			write_reg(8'h9f, 8'h0f, 8'h60);
			read_reg(8'h9f, 8'h0f, 1'b1);
			write_reg(8'h9f, 8'h0f, 8'h45);
			read_reg(8'h9f, 8'h0f, 1'b0);
			// reset in mid-run must bring every field back to zero
			resetn = 1'b0;
			repeat (3) @(negedge clock);
			resetn = 1'b1;
			mode_m = 3'h0;
			freq_m = 3'h0;
			read_reg(8'h9f, 8'h0f, 1'b0);
		end
		repeat (2) @(negedge clock);
		final_report();
	end
endmodule // tb_external_oscillator_control

// >>> rtl/ext_osc_consts.svh
`ifndef EXT_OSC_CONSTS_SVH
`define EXT_OSC_CONSTS_SVH

// special-function register location, reset values and unmapped read data of the control register
`define EXT_OSC_SFR_ADDR       8'h9f
`define EXT_OSC_SFR_PAGE       8'h0f
`define EXT_OSC_RESET          8'h00
`define EXT_OSC_FREQ_RESET     3'h0
`define EXT_OSC_MISS_DATA      8'h00

// field positions
`define EXT_OSC_VALID_BIT      7
`define EXT_OSC_MODE_HI        6
`define EXT_OSC_MODE_LO        4
`define EXT_OSC_UNUSED_BIT     3
`define EXT_OSC_FREQ_HI        2
`define EXT_OSC_FREQ_LO        0

// mode codes
`define EXT_OSC_MODE_OFF0      3'h0
`define EXT_OSC_MODE_OFF1      3'h1
`define EXT_OSC_MODE_LOGIC     3'h2
`define EXT_OSC_MODE_LOGIC_DIV 3'h3
`define EXT_OSC_MODE_RC        3'h4
`define EXT_OSC_MODE_CAP       3'h5
`define EXT_OSC_MODE_XTAL      3'h6
`define EXT_OSC_MODE_XTAL_DIV  3'h7

`endif

// >>> rtl/ext_osc_pkg.sv
package ext_osc_pkg;

	// one-hot oscillator configuration decoded from the mode field
	typedef enum logic [4:0] {
		OSC_OFF   = 5'h01,
		OSC_LOGIC = 5'h02,
		OSC_RC    = 5'h04,
		OSC_CAP   = 5'h08,
		OSC_XTAL  = 5'h10
	} osc_kind_e;

	// register image
	typedef struct packed {
		logic       crystal_valid_flag;
		logic [2:0] ext_osc_mode_select;
		logic       unused_zero;
		logic [2:0] ext_osc_freq_control;
	} ext_osc_control_s;

	// controls toward the analog oscillator and pin logic
	typedef struct packed {
		osc_kind_e  kind;
		logic       div_by_two;
		logic [2:0] freq_control;
		logic       crystal_in_pin_claim;
		logic       crystal_out_pin_claim;
	} osc_ctrl_s;

endpackage

// >>> rtl/external_oscillator_control.sv
`timescale 1ns/1ps
`include "ext_osc_consts.svh"
// Overview of operation
// R1 - the control register sits at sfr address 0x9f on page 0x0f and resets to zero (off).
// R2 - bit 7 is a read-only crystal valid flag that reads 1 only in crystal mode with a stable crystal.
// R3 - bits 6:4 are a read/write mode field: 00x off, 010 logic clock, 100 rc, 101 cap, 110 crystal.
// R4 - mode 011 is logic clock with divide by two and 111 is crystal with divide by two.
// R5 - bit 3 is unused, reads 0, and software writes 0 to it.
// R6 - in crystal mode software picks the frequency code from 000 (up to 32 kHz) to 111 (10-30 MHz).
// R7 - in rc mode code 000 covers up to 25 kHz, each code doubles, 111 covers 1.6-3.2 MHz.
// R8 - in capacitor mode the code picks a k factor from 0.87 (000) up to 1590 (111).
// R9 - software waits at least 1 ms after enabling crystal mode before sampling the valid flag.
// R10 - software drives the crystal pins high, makes them analog, enables, waits, polls, then switches.
// R11 - after a 32.768 kHz crystal settles software may drop the frequency code to 000.
// R12 - software does not switch the system clock to the crystal before it is stable.
// R13 - crystal mode claims both crystal pins; rc, cap and logic-clock modes claim only the out pin.
// R14 - writes ignore the valid flag and bit 3 and update only the mode and frequency fields.

module external_oscillator_control
(
	input  wire logic                  clock,
	input  wire logic                  resetn,
	input  wire logic [7:0]            sfr_addr,
	input  wire logic [7:0]            sfr_page,
	input  wire logic                  sfr_wr,
	input  wire logic [7:0]            sfr_wdata,
	output logic      [7:0]            sfr_rdata,
	output logic                       sfr_sel,
	input  wire logic                  amp_detect_stable,
	output ext_osc_pkg::osc_ctrl_s     osc_ctrl
);

	// the block holds the register and decodes it; the 1 ms settle wait and the pin
	// preparation are left to software, which saves a long cycle counter here
	// a flag read before that wait may still show a premature 1 from the detector
	// register state
	logic [2:0] mode_r;
	logic [2:0] mode_nxt;
	logic [2:0] freq_r;
	logic [2:0] freq_nxt;
	// amplitude detector comes from the analog domain: two-stage synchroniser
	logic       stable_meta_r;
	logic       stable_sync_r;
	logic       valid_r;
	logic       valid_nxt;
	logic       is_xtal;
	logic       hit;

	// the one sfr slot this block answers
	assign hit     = (sfr_addr == `EXT_OSC_SFR_ADDR) && (sfr_page == `EXT_OSC_SFR_PAGE); // see R1
	assign sfr_sel = hit;
	// crystal modes are 11x; read by the flag and pin checks below
	assign is_xtal = (mode_r == `EXT_OSC_MODE_XTAL) || (mode_r == `EXT_OSC_MODE_XTAL_DIV);

	// next-state for the register and flag
	always_comb
	begin
		mode_nxt  = mode_r;
		freq_nxt  = freq_r;
		if (hit && sfr_wr)
		begin
			// flag and bit 3 ignored on write
			mode_nxt = sfr_wdata[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO]; // see R3 see R14
			freq_nxt = sfr_wdata[`EXT_OSC_FREQ_HI:`EXT_OSC_FREQ_LO]; // see R14
		end
		// valid only in crystal mode; drops at once when mode leaves crystal
		valid_nxt = stable_sync_r &&
			((mode_nxt == `EXT_OSC_MODE_XTAL) || (mode_nxt == `EXT_OSC_MODE_XTAL_DIV)); // see R2
	end

	// registers, synchronous active-low reset to all zeros
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			mode_r        <= `EXT_OSC_MODE_OFF0; // see R1
			freq_r        <= `EXT_OSC_FREQ_RESET;
			stable_meta_r <= 1'b0;
			stable_sync_r <= 1'b0;
			valid_r       <= 1'b0;
		end
		else
		begin
			mode_r        <= mode_nxt;
			freq_r        <= freq_nxt;
			stable_meta_r <= amp_detect_stable;
			stable_sync_r <= stable_meta_r;
			valid_r       <= valid_nxt;
		end
	end

	// read image; unused bit always zero
	always_comb
	begin
		sfr_rdata = `EXT_OSC_RESET;
		if (hit)
		begin
			sfr_rdata[`EXT_OSC_VALID_BIT]                   = valid_r; // see R2
			sfr_rdata[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO]    = mode_r;
			sfr_rdata[`EXT_OSC_UNUSED_BIT]                  = 1'b0; // see R5
			sfr_rdata[`EXT_OSC_FREQ_HI:`EXT_OSC_FREQ_LO]    = freq_r;
		end
	end

	// decode mode into oscillator controls and pin claims
	always_comb
	begin
		osc_ctrl.freq_control          = freq_r; // code meaning set by software, see R6 see R7 see R8
		osc_ctrl.div_by_two            = 1'b0;
		osc_ctrl.crystal_in_pin_claim  = 1'b0;
		osc_ctrl.crystal_out_pin_claim = 1'b1;
		case (mode_r)
			`EXT_OSC_MODE_LOGIC:
				osc_ctrl.kind = ext_osc_pkg::OSC_LOGIC; // see R3
			`EXT_OSC_MODE_LOGIC_DIV:
			begin
				osc_ctrl.kind       = ext_osc_pkg::OSC_LOGIC;
				osc_ctrl.div_by_two = 1'b1; // see R4
			end
			`EXT_OSC_MODE_RC:
				osc_ctrl.kind = ext_osc_pkg::OSC_RC;
			`EXT_OSC_MODE_CAP:
				osc_ctrl.kind = ext_osc_pkg::OSC_CAP;
			`EXT_OSC_MODE_XTAL:
			begin
				osc_ctrl.kind                 = ext_osc_pkg::OSC_XTAL;
				osc_ctrl.crystal_in_pin_claim = 1'b1; // see R13
			end
			`EXT_OSC_MODE_XTAL_DIV:
			begin
				osc_ctrl.kind                 = ext_osc_pkg::OSC_XTAL;
				osc_ctrl.div_by_two           = 1'b1; // see R4
				osc_ctrl.crystal_in_pin_claim = 1'b1; // see R13
			end
			default:
			begin
				// 00x: circuit off, no pins held
				osc_ctrl.kind                  = ext_osc_pkg::OSC_OFF;
				osc_ctrl.crystal_out_pin_claim = 1'b0; // see R13
			end
		endcase
	end

	// flag checks: the flag stands only in crystal mode and tracks the synchronised detector
	a_valid_needs_xtal: assert property (@(posedge clock) disable iff (!resetn) // see R2
		valid_r |-> is_xtal)
		else $error("valid flag set outside crystal mode");
	a_valid_follows_sync: assert property (@(posedge clock) disable iff (!resetn) // see R2
		(stable_sync_r && (mode_nxt inside {`EXT_OSC_MODE_XTAL, `EXT_OSC_MODE_XTAL_DIV}))
			|=> valid_r)
		else $error("valid flag missed stable crystal");
	// a synchronised detector drop must clear the flag one edge later, so the flag outlives the synchronised detector by at most one cycle
	a_valid_drops: assert property (@(posedge clock) disable iff (!resetn) // see R2
		!stable_sync_r |=> !valid_r)
		else $error("valid flag outlived the detector");

	// write side: a hit lands both fields whole, nothing else moves them
	a_write_updates: assert property (@(posedge clock) disable iff (!resetn) // see R14
		(hit && sfr_wr) |=>
			(mode_r == $past(sfr_wdata[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO])) &&
			(freq_r == $past(sfr_wdata[`EXT_OSC_FREQ_HI:`EXT_OSC_FREQ_LO])))
		else $error("register write lost");
	a_hold_no_write: assert property (@(posedge clock) disable iff (!resetn) // see R14
		!(hit && sfr_wr) |=> ($stable(mode_r) && $stable(freq_r)))
		else $error("register changed without write");

	// read side: a hit shows the image with bit 3 low, anything else reads as zero
	a_read_image: assert property (@(posedge clock) disable iff (!resetn) // see R2
		hit |-> (sfr_rdata == {valid_r, mode_r, 1'h0, freq_r}))
		else $error("read image does not match the register");
	a_unused_zero: assert property (@(posedge clock) disable iff (!resetn) // see R5
		sfr_rdata[`EXT_OSC_UNUSED_BIT] == 1'h0)
		else $error("unused bit reads one");
	a_miss_reads_zero: assert property (@(posedge clock) disable iff (!resetn) // see R1
		!hit |-> (sfr_rdata == `EXT_OSC_MISS_DATA))
		else $error("unmapped read not zero");

	// pin claims and decode: off holds nothing, crystal holds both pins, the rest one
	a_off_no_pins: assert property (@(posedge clock) disable iff (!resetn) // see R13
		(mode_r inside {`EXT_OSC_MODE_OFF0, `EXT_OSC_MODE_OFF1})
			|-> (!osc_ctrl.crystal_out_pin_claim && !osc_ctrl.crystal_in_pin_claim))
		else $error("pins claimed while off");
	a_xtal_both_pins: assert property (@(posedge clock) disable iff (!resetn) // see R13
		is_xtal |-> (osc_ctrl.crystal_in_pin_claim && osc_ctrl.crystal_out_pin_claim))
		else $error("crystal mode without both pins");
	a_one_pin_modes: assert property (@(posedge clock) disable iff (!resetn) // see R13
		(mode_r inside {`EXT_OSC_MODE_LOGIC, `EXT_OSC_MODE_LOGIC_DIV,
			`EXT_OSC_MODE_RC, `EXT_OSC_MODE_CAP})
			|-> (osc_ctrl.crystal_out_pin_claim && !osc_ctrl.crystal_in_pin_claim))
		else $error("one-pin mode holds the wrong pins");
	a_kind_one_hot: assert property (@(posedge clock) disable iff (!resetn) // see R3
		$onehot(osc_ctrl.kind))
		else $error("oscillator kind not one-hot");
	a_xtal_kind: assert property (@(posedge clock) disable iff (!resetn) // see R3
		is_xtal |-> (osc_ctrl.kind == ext_osc_pkg::OSC_XTAL))
		else $error("crystal mode decoded as another kind");
	a_div_codes: assert property (@(posedge clock) disable iff (!resetn) // see R4
		osc_ctrl.div_by_two
			|-> (mode_r inside {`EXT_OSC_MODE_LOGIC_DIV, `EXT_OSC_MODE_XTAL_DIV}))
		else $error("divide stage in wrong mode");
	a_div_needed: assert property (@(posedge clock) disable iff (!resetn) // see R4
		(mode_r inside {`EXT_OSC_MODE_LOGIC_DIV, `EXT_OSC_MODE_XTAL_DIV})
			|-> osc_ctrl.div_by_two)
		else $error("divide stage missing");

	// no disable here: reset itself is the antecedent
	a_reset_zero: assert property (@(posedge clock) // see R1
		!resetn |=> ((mode_r == `EXT_OSC_MODE_OFF0) && (freq_r == `EXT_OSC_FREQ_RESET)
			&& !valid_r))
		else $error("reset value not zero");

	// main scenarios
	c_xtal_valid: cover property (@(posedge clock) disable iff (!resetn)
		(mode_r == `EXT_OSC_MODE_XTAL) ##[1:8] valid_r);
	c_logic_div: cover property (@(posedge clock) disable iff (!resetn)
		mode_r == `EXT_OSC_MODE_LOGIC_DIV);
	c_cap_mode: cover property (@(posedge clock) disable iff (!resetn)
		mode_r == `EXT_OSC_MODE_CAP);
	c_rc_mode: cover property (@(posedge clock) disable iff (!resetn)
		mode_r == `EXT_OSC_MODE_RC);
	c_valid_drop: cover property (@(posedge clock) disable iff (!resetn) valid_r ##1 !valid_r);

endmodule // external_oscillator_control
